// [hdl/bbs_host.sv]
// Purpose: Host-side controller driving a battery-backed 2K x 8 async SRAM.
// Assumes: power_fail_n pin is open-collector, pulled up, sampled through sync.
// Notes: One request at a time; accepts when req_ready is high.
`timescale 1ns/1ps
`default_nettype none
module bbs_host
    import bbs_pkg::*;
#(
    parameter int RECOVERY_CYC = POWER_UP_RECOVERY_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic power_ok,
    output logic first_write_pending,
    output logic chip_enable_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic [ADDR_W-1:0] sram_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic power_fail_output
);
    logic pf_sync;
    logic [DATA_W-1:0] dq_sync;
    bbs_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] pwr_cnt_q, pwr_cnt_d;
    logic power_ok_q, power_ok_d;
    logic first_q, first_d;
    logic ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
    logic dq_oe_q, dq_oe_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic ready_q, ready_d, rsp_q, rsp_d;

    // Pin synchronisers
    bbs_sync #(.WIDTH(1)) u_pf_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(power_fail_output),
        .sync_out(pf_sync)
    );
    bbs_sync #(.WIDTH(DATA_W)) u_dq_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(dq_in),
        .sync_out(dq_sync)
    );

    // Power supervision: low power-fail blocks access, then recovery wait
    always_comb begin
        pwr_cnt_d = pwr_cnt_q;
        power_ok_d = power_ok_q;
        first_d = first_q;
        // Finished write clears the flag; a power fail in the same cycle wins
        if (state_q == BBS_WR_STROBE && state_d == BBS_WR_RECOVER) begin
            first_d = 1'b0;
        end
        if (!pf_sync) begin
            power_ok_d = 1'b0;
            pwr_cnt_d = '0;
            first_d = 1'b1;
        end else if (!power_ok_q) begin
            if (pwr_cnt_q >= CNT_W'(RECOVERY_CYC - 1)) begin
                power_ok_d = 1'b1;
            end else begin
                pwr_cnt_d = pwr_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_cnt_q <= '0;
            power_ok_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            pwr_cnt_q <= pwr_cnt_d;
            power_ok_q <= power_ok_d;
            first_q <= first_d;
        end
    end

    // Access sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ce_n_d = ce_n_q;
        we_n_d = we_n_q;
        oe_n_d = oe_n_q;
        dq_oe_d = dq_oe_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        ready_d = 1'b0;
        rsp_d = 1'b0;
        case (state_q)
            BBS_IDLE: begin
                ce_n_d = 1'b1;
                we_n_d = 1'b1;
                oe_n_d = 1'b1;
                dq_oe_d = 1'b0;
                if (!power_ok_q) begin
                    state_d = BBS_WAIT_POWER;
                end else if (req_valid && ready_q) begin
                    addr_d = req_addr;
                    wdata_d = req_wdata;
                    ce_n_d = 1'b0;
                    cnt_d = '0;
                    if (req_write) begin
                        we_n_d = 1'b0;
                        state_d = BBS_WR_STROBE;
                    end else begin
                        oe_n_d = 1'b0;
                        state_d = BBS_RD_ACCESS;
                    end
                end else begin
                    // Ready only if power still good next cycle, so a shown ready is taken
                    ready_d = power_ok_d;
                end
            end
            BBS_WR_STROBE: begin
                // Drive data only after device outputs are off
                if (cnt_q >= CNT_W'(OUTPUT_OFF_CYC)) begin
                    dq_oe_d = 1'b1;
                end
                if (cnt_q >= CNT_W'(WRITE_PULSE_CYC + DATA_SETUP_CYC)) begin
                    we_n_d = 1'b1;
                    ce_n_d = 1'b1;
                    cnt_d = '0;
                    state_d = BBS_WR_RECOVER;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BBS_WR_RECOVER: begin
                dq_oe_d = 1'b0;
                if (cnt_q >= CNT_W'(WRITE_RECOVERY_CYC)) begin
                    rsp_d = 1'b1;
                    state_d = BBS_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BBS_RD_ACCESS: begin
                // Allow two extra cycles for the synchroniser
                if (cnt_q >= CNT_W'(READ_ACCESS_CYC + 2)) begin
                    rdata_d = dq_sync;
                    ce_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    cnt_d = '0;
                    state_d = BBS_RD_RELEASE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BBS_RD_RELEASE: begin
                // Bus floats before next access
                if (cnt_q >= CNT_W'(OUTPUT_OFF_CYC)) begin
                    rsp_d = 1'b1;
                    state_d = BBS_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BBS_WAIT_POWER: begin
                ce_n_d = 1'b1;
                we_n_d = 1'b1;
                oe_n_d = 1'b1;
                dq_oe_d = 1'b0;
                if (power_ok_q) begin
                    state_d = BBS_IDLE;
                end
            end
            default: begin
                state_d = BBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= BBS_IDLE;
            cnt_q <= '0;
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            dq_oe_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            ready_q <= 1'b0;
            rsp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ce_n_q <= ce_n_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            dq_oe_q <= dq_oe_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            rsp_q <= rsp_d;
        end
    end

    // Outputs straight from flip-flops
    assign req_ready = ready_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign power_ok = power_ok_q;
    assign first_write_pending = first_q;
    assign chip_enable_n = ce_n_q;
    assign write_enable_n = we_n_q;
    assign output_enable_n = oe_n_q;
    assign sram_addr = addr_q;
    assign dq_out = wdata_q;
    assign dq_oe = dq_oe_q;
endmodule
`default_nettype wire

// [shared/bbs_pkg.sv]
// Purpose: Constants for the battery-backed SRAM host controller.
// Assumes: 200 MHz mclk, 5 ns period.
// Notes: Times are kept in their own units; cycle counts derive from them.
package bbs_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CLK_PS = 5000;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    // Write pulse width, least, ns
    localparam int WRITE_PULSE_NS = 90;
    // Data setup before terminating edge, least, ns
    localparam int DATA_SETUP_NS = 40;
    // Write recovery interval, least, ns
    localparam int WRITE_RECOVERY_NS = 10;
    // Read cycle / access time, ns
    localparam int READ_ACCESS_NS = 150;
    // Output enable data off time, longest, ns
    localparam int OUTPUT_OFF_NS = 35;
    // Write strobe output off time, ns
    localparam int WRITE_STROBE_OUTPUT_OFF_NS = 50;
    // Power-up recovery time, least, ms
    localparam int POWER_UP_RECOVERY_MS = 2;
    // Power-down lead time, least, us
    localparam int POWER_DOWN_LEAD_US = 0;
    // Counts rounded up, at least one cycle
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int OUTPUT_OFF_CYC = (OUTPUT_OFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int POWER_UP_RECOVERY_CYC = POWER_UP_RECOVERY_MS * 1000 * CLK_MHZ;
    localparam int POWER_DOWN_LEAD_CYC = (POWER_DOWN_LEAD_US * CLK_MHZ < 1) ? 1 :
        POWER_DOWN_LEAD_US * CLK_MHZ;
    localparam int CNT_W = 20;
    typedef enum logic [2:0] {
        BBS_IDLE = 3'b000,
        BBS_WR_STROBE = 3'b001,
        BBS_WR_RECOVER = 3'b010,
        BBS_RD_ACCESS = 3'b011,
        BBS_RD_RELEASE = 3'b100,
        BBS_WAIT_POWER = 3'b101
    } bbs_state_t;
endpackage

// [hdl/bbs_sync.sv]
// Purpose: Two flip-flop synchroniser for asynchronous level inputs.
// Assumes: Input is a plain level from a pin.
// Notes: Only the second stage is visible to logic.
`timescale 1ns/1ps
`default_nettype none
module bbs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    // Two-stage capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= '0;
            sync_out <= '0;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule
`default_nettype wire

// [test/bbs_host_sva.sv]
// Purpose: Port checks for the SRAM host controller.
// Assumes: Bound to bbs_host, sees its ports only.
// Notes: A counter measures the write strobe low time.
`timescale 1ns/1ps
`default_nettype none
module bbs_host_sva
    import bbs_pkg::*;
#(
    parameter int RECOVERY_CYC = 20
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic power_ok,
    input wire logic first_write_pending,
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic power_fail_output
);
    logic [CNT_W-1:0] wcnt_q, wcnt_d;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles spent with the write strobe low
    always_comb begin
        wcnt_d = write_enable_n ? 20'h0 : wcnt_q + 20'h1;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_q <= 20'h0;
        end else begin
            wcnt_q <= wcnt_d;
        end
    end
    a_write_both_low: assert property ($fell(write_enable_n) |-> !chip_enable_n)
        else $error("write strobe without chip enable");
    a_pulse_width: assert property ($rose(write_enable_n) |-> wcnt_q >= WRITE_PULSE_CYC)
        else $error("write pulse too short");
    a_data_held: assert property ($rose(write_enable_n) |-> dq_oe && $past(dq_oe, 8))
        else $error("data not held over write end");
    a_addr_stable: assert property (!chip_enable_n && !$past(chip_enable_n) |-> $stable(sram_addr))
        else $error("address moved during access");
    a_we_recovery: assert property ($rose(write_enable_n) |=> write_enable_n [*2])
        else $error("write recovery too short");
    a_no_contention: assert property (!output_enable_n |-> !dq_oe && write_enable_n)
        else $error("host drives data in read");
    a_enable_gate: assert property ($fell(chip_enable_n) |-> $past(power_ok))
        else $error("access started without power");
    a_pf_drop: assert property ($fell(power_fail_output) |-> ##[1:4] !power_ok)
        else $error("power_ok stayed high");
endmodule
bind bbs_host bbs_host_sva #(.RECOVERY_CYC(RECOVERY_CYC)) u_sva (.mclk, .rst_n, .req_valid,
    .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .power_ok,
    .first_write_pending, .chip_enable_n, .write_enable_n, .output_enable_n, .sram_addr,
    .dq_out, .dq_oe, .dq_in, .power_fail_output);
`default_nettype wire

// [test/bbs_sram_model.sv]
// Purpose: Behavioural battery-backed 2K x 8 SRAM.
// Assumes: supply_good high means supply above the upper trip.
// Notes: Writes land at the end of write mode.
`timescale 1ns/1ps
`default_nettype none
module bbs_sram_model
    import bbs_pkg::*;
(
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic [DATA_W-1:0] dq_bus,
    input wire logic supply_good,
    input wire logic battery_low,
    output logic [DATA_W-1:0] dev_dq,
    output logic dev_oe,
    output logic power_fail_output,
    output logic battery_ok
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic wr_on = 1'b0;
    logic first_wr = 1'b1;
    // Battery taken as good at the start of the run
    initial battery_ok = 1'b1;
    // Battery check on each power-up
    always @(posedge supply_good) begin
        battery_ok = !battery_low;
        first_wr = 1'b1;
    end
    // Pulled-up pin, low while protected
    assign power_fail_output = supply_good;
    // Write opens at the later fall, stores at the earlier rise
    always @(chip_enable_n or write_enable_n or supply_good) begin
        if (!chip_enable_n && !write_enable_n && supply_good) begin
            wr_on = 1'b1;
        end else if (wr_on) begin
            wr_on = 1'b0;
            if (supply_good && !(first_wr && !battery_ok)) begin
                mem[sram_addr] = dq_bus;
            end
            first_wr = 1'b0;
        end
    end
    // Drive data only in read mode with output enable
    assign dev_oe = supply_good && !chip_enable_n && !output_enable_n && write_enable_n;
    assign dev_dq = mem[sram_addr];
endmodule
`default_nettype wire

// [test/bbs_host_tb.sv]
// Purpose: Self-checking bench for the SRAM host controller.
// Assumes: Short recovery count in simulation.
// Notes: Data wire shows the inverse of its last level when floating.
`timescale 1ns/1ps
`default_nettype none
module bbs_host_tb import bbs_pkg::*; ();
    localparam int RCY = 20;
    logic mclk = 1'b0;
    logic rst_n, req_valid, req_write, req_ready, rsp_valid, power_ok, first_write_pending;
    logic chip_enable_n, write_enable_n, output_enable_n, dq_oe, power_fail_output;
    logic dev_oe, supply_good, battery_low, battery_ok;
    logic [ADDR_W-1:0] req_addr, sram_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq_in, dev_dq;
    logic [DATA_W-1:0] last_dq = 8'h00;
    int miscompares = 0;
    int total_checks = 0;
    always #2.5 mclk = ~mclk;
    // Resolved data wire
    assign dq_in = dq_oe ? dq_out : (dev_oe ? dev_dq : ~last_dq);
    always @(posedge mclk) if (dq_oe || dev_oe) last_dq <= dq_in;
    bbs_host #(.RECOVERY_CYC(RCY)) uut (.mclk, .rst_n, .req_valid, .req_write, .req_addr,
        .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .power_ok, .first_write_pending,
        .chip_enable_n, .write_enable_n, .output_enable_n, .sram_addr, .dq_out, .dq_oe,
        .dq_in, .power_fail_output);
    bbs_sram_model u_dev (.chip_enable_n, .write_enable_n, .output_enable_n, .sram_addr,
        .dq_bus(dq_in), .supply_good, .battery_low, .dev_dq, .dev_oe, .power_fail_output,
        .battery_ok);
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, held until taken, then wait for completion
    task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(negedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        chk("req_ready", 11'h1, 11'(req_ready));
        @(posedge mclk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 100);
        chk("rsp_valid", 11'h1, 11'(rsp_valid));
        @(posedge mclk);
    endtask
    task automatic t_basic();
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (power_ok !== 1'b1 && n < 200);
        chk("power_ok", 11'h1, 11'(power_ok));
        chk("first pending", 11'h1, 11'(first_write_pending));
        @(posedge mclk);
        access(1'b1, 11'h000, 8'h5a);
        chk("first pending", 11'h0, 11'(first_write_pending));
        access(1'b1, 11'h7ff, 8'ha5);
        chk("top byte", 11'h0a5, 11'(u_dev.mem[11'h7ff]));
        access(1'b0, 11'h000, 8'h00);
        chk("read low", 11'h05a, 11'(rsp_rdata));
        access(1'b0, 11'h7ff, 8'h00);
        chk("read top", 11'h0a5, 11'(rsp_rdata));
    endtask
    // Request held across a power fail
    task automatic t_protect();
        int n;
        n = 0;
        supply_good <= 1'b0;
        repeat (9) @(posedge mclk);
        @(negedge mclk);
        chk("power_ok", 11'h0, 11'(power_ok));
        @(posedge mclk);
        fork
            access(1'b1, 11'h123, 8'h3c);
            begin
                repeat (30) begin
                    @(negedge mclk);
                    if (chip_enable_n !== 1'b1) n++;
                end
                @(posedge mclk);
                supply_good <= 1'b1;
            end
        join
        chk("enables off", 11'h0, 11'(n));
        chk("late write", 11'h03c, 11'(u_dev.mem[11'h123]));
    endtask
    // Low battery drops the first write
    task automatic t_battery();
        battery_low <= 1'b1;
        supply_good <= 1'b0;
        repeat (9) @(posedge mclk);
        @(negedge mclk);
        chk("pending again", 11'h1, 11'(first_write_pending));
        @(posedge mclk);
        supply_good <= 1'b1;
        access(1'b1, 11'h000, 8'h33);
        chk("battery flag", 11'h0, 11'(battery_ok));
        access(1'b0, 11'h000, 8'h00);
        chk("dropped write", 11'h05a, 11'(rsp_rdata));
        access(1'b1, 11'h000, 8'h33);
        access(1'b0, 11'h000, 8'h00);
        chk("kept write", 11'h033, 11'(rsp_rdata));
        battery_low <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 11'h000;
        req_wdata = 8'h00;
        supply_good = 1'b1;
        battery_low = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_basic();
        t_protect();
        t_battery();
        report_and_stop();
    end
    // Watchdog
    initial begin
        #50us;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
